//--- design/general_purpose_io_port.sv
// Purpose: two general-purpose I/O ports (3 and 4 pins) behind AXI4-Lite
// Assumes: stop/watch entry and interrupt enables come from outside blocks
// Notes:   pin inputs pass a three-stage synchroniser before any use
`include "gpio_port_params.svh"

module general_purpose_io_port
  import gpio_port_pkg::*;
#(
  parameter int A_PINS = 3,
  parameter int B_PINS = 4
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // standby and interrupt enables
  input  wire logic              standby_active,
  input  wire logic              ext_interrupt_control_first,
  input  wire logic              interrupt_pin_select_register,
  // port a pins and peripherals
  input  wire logic [A_PINS-1:0] port_a_pin_in,
  output logic [A_PINS-1:0]      port_a_pin_out,
  output logic [A_PINS-1:0]      port_a_pin_oe_n,
  output logic [A_PINS-1:0]      port_a_pullup_on,
  input  wire logic [A_PINS-1:0] port_a_periph_oe,
  input  wire logic [A_PINS-1:0] port_a_periph_out,
  output logic [A_PINS-1:0]      port_a_periph_in,
  // port b pins and peripherals
  input  wire logic [B_PINS-1:0] port_b_pin_in,
  output logic [B_PINS-1:0]      port_b_pin_out,
  output logic [B_PINS-1:0]      port_b_pin_oe_n,
  output logic [B_PINS-1:0]      port_b_pullup_on,
  input  wire logic [B_PINS-1:0] port_b_periph_oe,
  input  wire logic [B_PINS-1:0] port_b_periph_out,
  output logic [B_PINS-1:0]      port_b_periph_in,
  // trigger routing
  input  wire logic              alternate_trigger_pin,
  output logic                   ppg_trigger_input,
  output logic                   adc_trigger_input
);

  localparam int NP = A_PINS + B_PINS;
  localparam int NS = NP + 1;

  generate
    if (A_PINS < 1 || A_PINS > 8 || B_PINS < 1 || B_PINS > 8) begin : g_bad_width
      $error("port widths must be 1 to 8");
    end
    if (B_PINS <= `TRIG_PIN_IDX) begin : g_bad_trig
      $error("port b too narrow for the trigger pin");
    end
    if (`SYNC_STAGES != 3) begin : g_bad_sync
      $error("synchroniser is built for three stages");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [A_PINS-1:0]     a_latch_q;
  logic [A_PINS-1:0]     a_dir_q;
  logic [A_PINS-1:0]     a_pull_q;
  logic [B_PINS-1:0]     b_latch_q;
  logic [B_PINS-1:0]     b_dir_q;
  logic [B_PINS-1:0]     b_pull_q;
  logic [`CTRL_WIDTH-1:0] ctrl_q;

  logic                  aw_have_q;
  logic                  w_have_q;
  logic [7:0]            aw_addr_q;
  logic [31:0]           w_data_q;
  logic                  w_lane0_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  logic                  do_write;
  logic                  wr_hit;
  logic [7:0]            wbyte;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // register update and raised bvalid share one edge, so software
  // never reads a stale value once it has its answer
  // both halves held; address and data may come in either order
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign wbyte    = w_data_q[7:0];

  // unmapped offsets answer with an error and write nothing
  always_comb begin
    case (aw_addr_q)
      `OFS_A_DATA, `OFS_A_DIR, `OFS_A_PULLUP,
      `OFS_B_DATA, `OFS_B_DIR, `OFS_B_PULLUP,
      `OFS_CTRL, `OFS_A_LATCH, `OFS_B_LATCH: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q  <= 1'b1;
      w_data_q  <= s_axi_wdata;
      w_lane0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  // do_write cannot fire while bvalid stands, so set and clear never meet
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= resp_okay;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // only byte lane 0 carries register bits; other lanes are ignored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_latch_q <= A_PINS'(`RST_LATCH);
      b_latch_q <= B_PINS'(`RST_LATCH);
    end else if (do_write && w_lane0_q) begin
      // latch view offset stores the same latch as the data offset
      if (aw_addr_q == `OFS_A_DATA || aw_addr_q == `OFS_A_LATCH) begin
        a_latch_q <= wbyte[A_PINS-1:0];
      end
      if (aw_addr_q == `OFS_B_DATA || aw_addr_q == `OFS_B_LATCH) begin
        b_latch_q <= wbyte[B_PINS-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_dir_q <= A_PINS'(`RST_DIR);
      b_dir_q <= B_PINS'(`RST_DIR);
    end else if (do_write && w_lane0_q) begin
      if (aw_addr_q == `OFS_A_DIR) begin
        a_dir_q <= wbyte[A_PINS-1:0];
      end
      if (aw_addr_q == `OFS_B_DIR) begin
        b_dir_q <= wbyte[B_PINS-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_pull_q <= A_PINS'(`RST_PULLUP);
      b_pull_q <= B_PINS'(`RST_PULLUP);
    end else if (do_write && w_lane0_q) begin
      if (aw_addr_q == `OFS_A_PULLUP) begin
        a_pull_q <= wbyte[A_PINS-1:0];
      end
      if (aw_addr_q == `OFS_B_PULLUP) begin
        b_pull_q <= wbyte[B_PINS-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `RST_CTRL;
    end else if (do_write && w_lane0_q && aw_addr_q == `OFS_CTRL) begin
      ctrl_q <= wbyte[`CTRL_WIDTH-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser and blocking

  logic [NS-1:0] raw_in;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  logic [NS-1:0] filt_q;
  logic          forced;
  logic          trig_keep;
  logic [NP-1:0] pin_int;

  assign raw_in = {alternate_trigger_pin, port_b_pin_in, port_a_pin_in};

  // stage one may be metastable, so only stage two reads it
  // a level is accepted only once two late stages agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NS; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign forced    = standby_active && ctrl_q[`CTRL_PIN_STATE_BIT];
  // only port b pin 3 can be exempted, through its interrupt enables
  assign trig_keep = ext_interrupt_control_first && interrupt_pin_select_register;

  //////////////////////////////////////////////////////////////////////////////
  // per-pin drive, pull-up and input path

  logic [NP-1:0] latch_all;
  logic [NP-1:0] dir_all;
  logic [NP-1:0] pull_all;
  logic [NP-1:0] poe_all;
  logic [NP-1:0] pout_all;
  logic [NP-1:0] out_all;
  logic [NP-1:0] drv_all;
  logic [NP-1:0] pu_all;
  logic [NP-1:0] rd_all;

  assign latch_all = {b_latch_q, a_latch_q};
  assign dir_all   = {b_dir_q, a_dir_q};
  assign pull_all  = {b_pull_q, a_pull_q};
  assign poe_all   = {port_b_periph_oe, port_a_periph_oe};
  assign pout_all  = {port_b_periph_out, port_a_periph_out};

  generate
    for (genvar i = 0; i < NP; i++) begin : g_pin
      logic keep;
      assign keep = (i == A_PINS + `TRIG_PIN_IDX) && trig_keep;
      // peripheral output wins over port output
      assign out_all[i] = poe_all[i] ? pout_all[i] : latch_all[i];
      assign drv_all[i] = !forced && (poe_all[i] || dir_all[i]);
      // pull-up drops only while the pin is really driven low
      assign pu_all[i]  = pull_all[i] && !(drv_all[i] && !out_all[i]);
      assign pin_int[i] = (forced && !keep) ? 1'b0 : filt_q[i];
      // port output mode reads the latch, anything else reads the pin
      assign rd_all[i]  = (dir_all[i] && !poe_all[i]) ? latch_all[i] : pin_int[i];
    end
  endgenerate

  assign port_a_pin_out   = out_all[A_PINS-1:0];
  assign port_b_pin_out   = out_all[NP-1:A_PINS];
  assign port_a_pin_oe_n  = ~drv_all[A_PINS-1:0];
  assign port_b_pin_oe_n  = ~drv_all[NP-1:A_PINS];
  assign port_a_pullup_on = pu_all[A_PINS-1:0];
  assign port_b_pullup_on = pu_all[NP-1:A_PINS];
  assign port_a_periph_in = pin_int[A_PINS-1:0];
  assign port_b_periph_in = pin_int[NP-1:A_PINS];

  //////////////////////////////////////////////////////////////////////////////
  // trigger routing

  // alternate pin is blocked in forced standby like the others
  always_comb begin
    if (ctrl_q[`CTRL_TRIG_SEL_BIT]) begin
      ppg_trigger_input = forced ? 1'b0 : filt_q[NP];
    end else begin
      ppg_trigger_input = pin_int[A_PINS + `TRIG_PIN_IDX];
    end
    adc_trigger_input = ppg_trigger_input;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read channel, one cycle after the address is taken

  logic [7:0]  ra;
  logic [31:0] rd_d;
  logic [1:0]  rr_d;

  assign ra = {s_axi_araddr[7:2], 2'b00};

  always_comb begin
    rd_d = 32'h0000_0000;
    rr_d = resp_okay;
    case (ra)
      `OFS_A_DATA:   rd_d[A_PINS-1:0] = rd_all[A_PINS-1:0];
      `OFS_B_DATA:   rd_d[B_PINS-1:0] = rd_all[NP-1:A_PINS];
      // latch view returns the latch whatever the direction
      `OFS_A_LATCH:  rd_d[A_PINS-1:0] = a_latch_q;
      `OFS_B_LATCH:  rd_d[B_PINS-1:0] = b_latch_q;
      `OFS_A_DIR:    rd_d[A_PINS-1:0] = a_dir_q;
      `OFS_B_DIR:    rd_d[B_PINS-1:0] = b_dir_q;
      `OFS_A_PULLUP: rd_d[A_PINS-1:0] = a_pull_q;
      `OFS_B_PULLUP: rd_d[B_PINS-1:0] = b_pull_q;
      `OFS_CTRL:     rd_d[`CTRL_WIDTH-1:0] = ctrl_q;
      default:       rr_d = resp_slverr;
    endcase
  end

  // arready stays low while rvalid stands: one read in flight at most
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_d;
      rresp_q  <= rr_d;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

//--- design/gpio_port_params.svh
// Purpose: register offsets, field positions and reset values of the port block
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, one aligned word each
// Notes:   definitions only
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

`define OFS_A_DATA     8'h00
`define OFS_A_DIR      8'h04
`define OFS_A_PULLUP   8'h08
`define OFS_B_DATA     8'h0C
`define OFS_B_DIR      8'h10
`define OFS_B_PULLUP   8'h14
`define OFS_CTRL       8'h18
`define OFS_A_LATCH    8'h20
`define OFS_B_LATCH    8'h24

`define CTRL_PIN_STATE_BIT 0
`define CTRL_TRIG_SEL_BIT  1
`define CTRL_WIDTH         2

`define RST_LATCH   8'h00
`define RST_DIR     8'h00
`define RST_PULLUP  8'h00
`define RST_CTRL    2'h0

`define TRIG_PIN_IDX 3
`define SYNC_STAGES  3

`endif

//--- design/gpio_port_pkg.sv
// Purpose: shared types of the port block
// Assumes: nothing
// Notes:   response codes as published for AXI4-Lite
package gpio_port_pkg;
  typedef enum logic [1:0] {
    resp_okay   = 2'h0,
    resp_slverr = 2'h2
  } axi_resp_e;
  typedef logic [31:0] word_t;
endpackage

//--- dv/gpio_port_checker_assertions.sv
// Purpose: bus and pin relations of the port block
// Assumes: one clock, rst_n asynchronous active low
// Notes:   sees only top-level ports
module gpio_port_checker #(
  parameter int A_PINS = 3
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              standby_active,
  input wire logic [A_PINS-1:0] port_a_pin_out,
  input wire logic [A_PINS-1:0] port_a_pin_oe_n,
  input wire logic [A_PINS-1:0] port_a_pullup_on,
  input wire logic [A_PINS-1:0] port_a_periph_oe,
  input wire logic [A_PINS-1:0] port_a_periph_out,
  input wire logic [A_PINS-1:0] port_a_periph_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_reset_inputs: assert property ($rose(rst_n) |-> &port_a_pin_oe_n)
    else $error("pin driven after reset");
  a_periph_value: assert property (!standby_active |->
    ((port_a_pin_out ^ port_a_periph_out) & port_a_periph_oe) == '0)
    else $error("peripheral value missing");
  a_periph_drive: assert property (!standby_active |->
    (port_a_pin_oe_n & port_a_periph_oe) == '0)
    else $error("peripheral pin not driven");
  a_pullup_drop: assert property (
    (port_a_pullup_on & ~port_a_pin_oe_n & ~port_a_pin_out) == '0)
    else $error("pull-up on a low output");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_standby_block: assert property (standby_active && $past(standby_active) &&
    port_a_periph_oe != '0 && $past(&port_a_pin_oe_n) && &port_a_pin_oe_n
    |-> port_a_periph_in == '0)
    else $error("input not blocked");
endmodule

bind general_purpose_io_port gpio_port_checker #(.A_PINS(A_PINS)) checker_i (
  .clock, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .standby_active,
  .port_a_pin_out, .port_a_pin_oe_n, .port_a_pullup_on, .port_a_periph_oe,
  .port_a_periph_out, .port_a_periph_in);

//--- dv/pin_board.sv
// Purpose: board side of one port
// Assumes: weak board source that an enabled pull-up overrides
// Notes:   a pin driven by the block reads back its own value
module pin_board #(
  parameter int N = 3
) (
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe_n,
  input  wire logic [N-1:0] pullup_on,
  input  wire logic [N-1:0] ext_val,
  output logic [N-1:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (pullup_on | ext_val));
endmodule

//--- dv/tb.sv
// Purpose: self-checking bench of the two-port I/O block
// Assumes: AXI4-Lite master tasks, board models on both ports
// Notes:   integer reference model, fixed-seed stimulus
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_port_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, standby_active = 1'b0;
  logic        ext_interrupt_control_first = 1'b0, interrupt_pin_select_register = 1'b0;
  logic        alternate_trigger_pin = 1'b0, ppg_trigger_input, adc_trigger_input;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  poe_c = 7'h00, pout_c = 7'h00, ext_c = 7'h00;
  logic [2:0]  port_a_pin_in, port_a_pin_out, port_a_pin_oe_n;
  logic [2:0]  port_a_pullup_on, port_a_periph_in;
  logic [3:0]  port_b_pin_in, port_b_pin_out, port_b_pin_oe_n;
  logic [3:0]  port_b_pullup_on, port_b_periph_in;
  wire  [2:0]  port_a_periph_oe = poe_c[2:0], port_a_periph_out = pout_c[2:0];
  wire  [3:0]  port_b_periph_oe = poe_c[6:3], port_b_periph_out = pout_c[6:3];
  wire  [6:0]  oe_n_c = {port_b_pin_oe_n, port_a_pin_oe_n};
  wire  [6:0]  out_c = {port_b_pin_out, port_a_pin_out};
  wire  [6:0]  pu_c = {port_b_pullup_on, port_a_pullup_on};
  wire  [6:0]  pi_c = {port_b_periph_in, port_a_periph_in};
  int          err_count = 0, n_checks = 0, cyc = 0;
  int          lat[2], dir[2], pu[2];
  logic [31:0] lfsr_q = 32'hC62D;

  always #12.5 clock = ~clock;

  general_purpose_io_port uut (
    .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .standby_active, .ext_interrupt_control_first,
    .interrupt_pin_select_register, .port_a_pin_in, .port_a_pin_out, .port_a_pin_oe_n,
    .port_a_pullup_on, .port_a_periph_oe, .port_a_periph_out, .port_a_periph_in,
    .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe_n, .port_b_pullup_on,
    .port_b_periph_oe, .port_b_periph_out, .port_b_periph_in, .alternate_trigger_pin,
    .ppg_trigger_input, .adc_trigger_input);
  pin_board #(.N(3)) board_a (.pin_out(port_a_pin_out), .pin_oe_n(port_a_pin_oe_n),
    .pullup_on(port_a_pullup_on), .ext_val(ext_c[2:0]), .pin_in(port_a_pin_in));
  pin_board #(.N(4)) board_b (.pin_out(port_b_pin_out), .pin_oe_n(port_b_pin_oe_n),
    .pullup_on(port_b_pullup_on), .ext_val(ext_c[6:3]), .pin_in(port_b_pin_in));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    repeat (32) lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // handshakes sampled at the falling edge: inputs only move after rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, bh;
    logic [1:0] resp;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!bh);
    s_axi_bready <= 1'b0;
    chk(32'(resp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ta, rh;
    logic [31:0] got;
    logic [1:0] resp;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      got = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!rh);
    s_axi_rready <= 1'b0;
    chk(got, exp);
    chk(32'(resp), 32'(er));
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      end_of_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int w, s, f, m, own, drv, val, lvl, blk, po, sh, trig;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd(8'(i * 4), 0, (i == 7) ? resp_slverr : resp_okay);
    wr(8'h1C, 32'hFFFF_FFFF, resp_slverr);
    s_axi_wstrb <= 4'hE;
    wr(8'h04, 32'h0000_00FF, resp_okay);
    s_axi_wstrb <= 4'hF;
    rd(8'h04, 0, resp_okay);
    for (int it = 0; it < 40; it++) begin
      for (int p = 0; p < 2; p++) begin
        m = p ? 15 : 7;
        w = rnd();
        wr(8'(it[0] ? 32 + p * 4 : p * 12), w, resp_okay);
        lat[p] = w & m;
        w = rnd();
        wr(8'(p * 12 + 4), w, resp_okay);
        dir[p] = w & m;
        w = rnd();
        wr(8'(p * 12 + 8), w, resp_okay);
        pu[p] = w & m;
      end
      w = rnd() & 3;
      wr(8'h18, w, resp_okay);
      s = rnd();
      standby_active <= s[0] & (it >= 24);
      ext_interrupt_control_first <= s[1];
      interrupt_pin_select_register <= s[2];
      alternate_trigger_pin <= s[3];
      poe_c <= (it >= 12) ? s[10:4] & ~7'(dir[1] * 8 + dir[0]) : 7'h00;
      pout_c <= s[17:11];
      ext_c <= s[24:18];
      repeat (6) @(posedge clock);
      for (int p = 0; p < 2; p++) begin
        @(negedge clock);
        m = p ? 15 : 7;
        sh = p * 3;
        f = standby_active & w[0];
        po = (poe_c >> sh) & m;
        drv = f ? 0 : (dir[p] | po);
        val = (po & (pout_c >> sh)) | (~po & lat[p]);
        lvl = (drv & val) | (~drv & ((ext_c >> sh) | pu[p]));
        own = dir[p] & ~po;
        blk = !f ? m : (p == 1 && s[1] && s[2]) ? 8 : 0;
        trig = w[1] ? (s[3] & !f) : ((lvl & blk) >> 3) & 1;
        chk((oe_n_c >> sh) & m, ~drv & m);
        chk((out_c >> sh) & drv, val & drv);
        chk((pu_c >> sh) & m, pu[p] & ~(drv & ~val));
        chk((pi_c >> sh) & m, lvl & blk & m);
        if (p == 1) chk({ppg_trigger_input, adc_trigger_input}, trig * 3);
        rd(8'(p * 12), ((own & lat[p]) | (~own & lvl & blk)) & m, resp_okay);
        rd(8'(32 + p * 4), lat[p], resp_okay);
      end
    end
    poe_c <= 7'h00;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int p = 0; p < 2; p++) rd(8'(p * 12 + 4), 0, resp_okay);
    end_of_test();
  end
endmodule
